/* rtl/sram_map.sv */
// standby ram: wishbone slave, base decode, space type, remap lock
//
// The Wishbone slave port and the address map were decided locally.
`default_nettype none
// Behaviour
// - 4 KB array, two-cycle read and write
// - base size-aligned; array wins over registers
// - byte, word and long-word accesses
// - registers answer supervisor data space only
// - module map bit gives top address bit
// - eight-byte block; unimplemented reads zero
// - base high and low place array
// - base writes need stop set, lock clear
// - lock set once, then frozen
// - space field: program+data or program only
// - supervisor-only mode leaves user accesses unclaimed
module sram_map
  import sram_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [23:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // access attributes from the core
  input  wire logic        supervisor,
  input  wire logic        program_space,
  // system integration unit
  input  wire logic        module_map_select,
  // decode result for outside logic
  output logic             access_claimed
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic        stop_reg,  stop_next;
  logic        base_lock_bit, lock_next;
  logic [1:0]  array_space_select, space_next;
  logic [7:0]  array_base_high_reg, base_high_next;
  logic [3:0]  array_base_low_reg,  base_low_next;
  logic        ack_reg,   ack_next;
  logic        err_reg,   err_next;
  logic        from_array_reg, from_array_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] ram_q;

  logic        req;
  logic        array_hit;
  logic        reg_hit;
  logic        space_ok;
  logic        commit;
  logic [11:0] base_addr;
  logic [15:0] ram_module_config_reg;
  logic [15:0] ram_test_reg;
  logic [15:0] base_high_word;
  logic [15:0] base_low_word;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // a new request is one not yet answered
  assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign base_addr = {array_base_high_reg, array_base_low_reg};

  // space check: stop mode parks the array off the bus
  always_comb begin
    space_ok = !stop_reg;
    if (array_space_select[SPACE_PROG_BIT] && !program_space) begin
      space_ok = 1'b0;
    end
    if (array_space_select[SPACE_SUPV_BIT] && !supervisor) begin
      space_ok = 1'b0;
    end
  end

  // array compares whole upper field, so any 4 KB boundary works
  assign array_hit = space_ok &&
                     (wb_adr_i[BUS_AW-1:BASE_LSB] == base_addr);

  // registers lose any overlap with the array
  assign reg_hit = !array_hit && supervisor && !program_space &&
                   (wb_adr_i[23] == module_map_select) &&
                   (wb_adr_i[22:3] == CTRL_BLOCK_BASE[22:3]);

  assign access_claimed = wb_cyc_i && wb_stb_i && (array_hit || reg_hit);

  // writes land on the edge where ack is seen high
  assign commit = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;

  // ---------------------------------------------------------------
  // register views; test word has no storage and reads zero
  // ---------------------------------------------------------------
  always_comb begin
    ram_module_config_reg = 16'h0000;
    ram_module_config_reg[CFG_STOP_BIT] = stop_reg;
    ram_module_config_reg[CFG_LOCK_BIT] = base_lock_bit;
    ram_module_config_reg[CFG_SPACE_LSB +: 2] = array_space_select;
    ram_test_reg   = 16'h0000;
    base_high_word = {8'h00, array_base_high_reg};
    base_low_word  = {array_base_low_reg, 12'h000};
  end

  // ---------------------------------------------------------------
  // bus handshake and read data
  // ---------------------------------------------------------------
  // ack one cycle after the request: two bus cycles in all
  always_comb begin
    ack_next        = req && (array_hit || reg_hit);
    err_next        = req && !(array_hit || reg_hit);
    from_array_next = from_array_reg;
    rdata_next      = rdata_reg;
    if (req) begin
      from_array_next = array_hit;
      rdata_next      = 32'h0000_0000;
      if (reg_hit && wb_adr_i[2] == CTRL_WORD_CFG) begin
        rdata_next = {ram_module_config_reg, ram_test_reg};
      end else if (reg_hit) begin
        rdata_next = {base_high_word, base_low_word};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_reg        <= 1'b0;
      err_reg        <= 1'b0;
      from_array_reg <= 1'b0;
      rdata_reg      <= 32'h0000_0000;
    end else begin
      ack_reg        <= ack_next;
      err_reg        <= err_next;
      from_array_reg <= from_array_next;
      rdata_reg      <= rdata_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_err_o = err_reg;
  assign wb_dat_o = from_array_reg ? ram_q : rdata_reg;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // lock and base are checked against values before this write
  always_comb begin
    stop_next      = stop_reg;
    lock_next      = base_lock_bit;
    space_next     = array_space_select;
    base_high_next = array_base_high_reg;
    base_low_next  = array_base_low_reg;
    if (commit && !from_array_reg && wb_adr_i[2] == CTRL_WORD_CFG) begin
      if (wb_sel_i[3]) begin
        stop_next = wb_dat_i[16 + CFG_STOP_BIT];
        // only a one sticks; zero never clears it
        lock_next = base_lock_bit | wb_dat_i[16 + CFG_LOCK_BIT];
      end
      if (wb_sel_i[2]) begin
        space_next = wb_dat_i[16 + CFG_SPACE_LSB +: 2];
      end
    end
    if (commit && !from_array_reg && wb_adr_i[2] == CTRL_WORD_BASE &&
        stop_reg && !base_lock_bit) begin
      if (wb_sel_i[2]) begin
        base_high_next = wb_dat_i[23:16];
      end
      if (wb_sel_i[1]) begin
        base_low_next = wb_dat_i[15:12];
      end
    end
  end

  // the lock drops only here, at reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stop_reg            <= STOP_RESET;
      base_lock_bit       <= LOCK_RESET;
      array_space_select  <= SPACE_RESET;
      array_base_high_reg <= BASE_HIGH_RESET;
      array_base_low_reg  <= BASE_LOW_RESET;
    end else begin
      stop_reg            <= stop_next;
      base_lock_bit       <= lock_next;
      array_space_select  <= space_next;
      array_base_high_reg <= base_high_next;
      array_base_low_reg  <= base_low_next;
    end
  end

  // ---------------------------------------------------------------
  // storage array
  // ---------------------------------------------------------------
  sram_array #(
    .WORDS (ARRAY_WORDS),
    .AW    (ARRAY_AW)
  ) u_array (
    .clk     (clk),
    .addr    (wb_adr_i[ARRAY_AW+1:2]),
    .wr_en   (commit && from_array_reg),
    .byte_en (wb_sel_i),
    .wr_data (wb_dat_i),
    .rd_data (ram_q)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_ack_timing: assert property (
    req && access_claimed |=> wb_ack_o ##1 !wb_ack_o)
    else $error("claimed access not acked in two cycles");
  chk_overlap_wins: assert property (
    array_hit |-> !reg_hit)
    else $error("registers decoded inside array window");
  chk_reg_supv_data: assert property (
    reg_hit |-> supervisor && !program_space)
    else $error("registers answered non supervisor data access");
  chk_map_top_bit: assert property (
    reg_hit |-> wb_adr_i[23] == module_map_select)
    else $error("register decode ignored module map bit");
  chk_test_word_zero: assert property (
    req && reg_hit && wb_adr_i[2] == CTRL_WORD_CFG |=>
      wb_dat_o[15:0] == 16'h0000)
    else $error("unimplemented word did not read zero");
  chk_base_decode: assert property (
    array_hit |-> wb_adr_i[23:12] == base_addr && !stop_reg)
    else $error("array hit outside its base window");
  chk_base_guard: assert property (
    commit && !from_array_reg && wb_adr_i[2] == CTRL_WORD_BASE &&
      (base_lock_bit || !stop_reg) |=> $stable(base_addr))
    else $error("base changed while locked or running");
  chk_lock_sticky: assert property (
    base_lock_bit |=> base_lock_bit)
    else $error("lock bit cleared without reset");
  chk_prog_only: assert property (
    array_space_select[SPACE_PROG_BIT] && !program_space |-> !array_hit)
    else $error("data access claimed in program only mode");
  chk_user_unclaimed: assert property (
    array_space_select[SPACE_SUPV_BIT] && !supervisor |-> !array_hit)
    else $error("user access claimed in supervisor only mode");
  chk_lock_reset: assert property (
    @(posedge clk) disable iff (1'b0)
    !reset_n |=> !base_lock_bit)
    else $error("lock not cleared by reset");

  // ---------------------------------------------------------------
  // handshake hygiene
  // ---------------------------------------------------------------
  // an unclaimed request must still end, or the core would hang
  chk_err_unclaimed: assert property (
    req && !access_claimed |=> wb_err_o ##1 !wb_err_o)
    else $error("unclaimed access not ended by err");
  // ack and err together would leave the master guessing
  chk_ack_err_excl: assert property (
    !(wb_ack_o && wb_err_o))
    else $error("ack and err raised together");
  // no answer without a cycle in flight
  chk_idle_no_ack: assert property (
    !wb_cyc_i |=> !wb_ack_o && !wb_err_o)
    else $error("answer given with no request");
  // stop parks the array, so it claims nothing then
  chk_stop_parks: assert property (
    stop_reg |-> !array_hit)
    else $error("array claimed while stopped");
  // a second lock write of zero must not unlock
  chk_lock_write_once: assert property (
    base_lock_bit && commit && !from_array_reg &&
      wb_adr_i[2] == CTRL_WORD_CFG |=> base_lock_bit)
    else $error("lock cleared by a register write");
  // config writes never touch the base words
  chk_cfg_keeps_base: assert property (
    commit && !from_array_reg && wb_adr_i[2] == CTRL_WORD_CFG |=>
      $stable(base_addr))
    else $error("config write moved the array base");

  cov_array_write: cover property (commit && from_array_reg);
  cov_array_read: cover property (wb_ack_o && !wb_we_i && from_array_reg);
  cov_lock_set: cover property (!base_lock_bit ##1 base_lock_bit);
  cov_user_err: cover property (req && !supervisor ##1 wb_err_o);
  // array laid over the register block, registers hidden
  cov_overlap: cover property (
    req && array_hit && wb_adr_i[22:3] == CTRL_BLOCK_BASE[22:3]);
endmodule : sram_map
`default_nettype wire

/* rtl/sram_pkg.sv */
// constants shared by the standby ram array mapping block
`default_nettype none
package sram_pkg;
  // -------------------------------------------------------------
  // array geometry
  // -------------------------------------------------------------
  localparam int          ARRAY_BYTES      = 4096;
  localparam int          ARRAY_WORDS      = ARRAY_BYTES / 4;
  localparam int          ARRAY_AW         = 10;
  localparam int          BUS_AW           = 24;
  localparam int          BASE_LSB         = 12;
  // -------------------------------------------------------------
  // control block placement, low 23 bits; bit 23 from module map
  // -------------------------------------------------------------
  localparam logic [22:0] CTRL_BLOCK_BASE  = 23'h7FFB40;
  localparam logic [0:0]  CTRL_WORD_CFG    = 1'h0;
  localparam logic [0:0]  CTRL_WORD_BASE   = 1'h1;
  // -------------------------------------------------------------
  // configuration register fields and reset values
  // -------------------------------------------------------------
  localparam int          CFG_STOP_BIT     = 15;
  localparam int          CFG_LOCK_BIT     = 14;
  localparam int          CFG_SPACE_LSB    = 8;
  localparam logic        STOP_RESET       = 1'h1;
  localparam logic        LOCK_RESET       = 1'h0;
  localparam logic [1:0]  SPACE_RESET      = 2'h3;
  localparam logic [7:0]  BASE_HIGH_RESET  = 8'h00;
  localparam logic [3:0]  BASE_LOW_RESET   = 4'h0;
  // space select: bit0 supervisor only, bit1 program only
  localparam int          SPACE_SUPV_BIT   = 0;
  localparam int          SPACE_PROG_BIT   = 1;
  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int          ACCESS_CYCLES    = 2;
endpackage : sram_pkg
`default_nettype wire

/* rtl/sram_array.sv */
// byte-lane writable static array, one 32-bit word per address
`default_nettype none
module sram_array
  import sram_pkg::*;
#(
  parameter int WORDS = ARRAY_WORDS,
  parameter int AW    = ARRAY_AW
) (
  // clock
  input  wire logic          clk,
  // access
  input  wire logic [AW-1:0] addr,
  input  wire logic          wr_en,
  input  wire logic [3:0]    byte_en,
  input  wire logic [31:0]   wr_data,
  output logic      [31:0]   rd_data
);
  logic [31:0] mem [WORDS];

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // read every cycle so data is ready when ack rises
  always_ff @(posedge clk) begin
    rd_data <= mem[addr];
    for (int i = 0; i < 4; i++) begin
      if (wr_en && byte_en[i]) begin
        mem[addr][8*i +: 8] <= wr_data[8*i +: 8];
      end
    end
  end
endmodule : sram_array
`default_nettype wire

/* testbench/sram_core_model.sv */
// core-side bus master model issuing classic wishbone single cycles
`default_nettype none
module sram_core_model
  import sram_pkg::*;
(
  // clock
  input  wire logic        clk,
  // bus request
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [23:0]      adr,
  output logic [3:0]       sel,
  output logic [31:0]      wdat,
  output logic             supervisor,
  output logic             program_space,
  // bus answer
  input  wire logic [31:0] rdat,
  input  wire logic        ack,
  input  wire logic        err,
  input  wire logic        claimed
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 24'h000000;
    sel = 4'h0;
    wdat = 32'h00000000;
    supervisor = 1'b1;
    program_space = 1'b0;
  end

  // one access; holds everything until ack or err is sampled
  task automatic access(input logic w, input logic [23:0] a,
                        input logic [3:0] s, input logic [31:0] d,
                        input logic sv, input logic pg,
                        output logic [31:0] q, output logic k,
                        output logic e, output logic c, output int n);
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    supervisor <= sv;
    program_space <= pg;
    do begin
      @(posedge clk);
      n++;
    end while (!(ack === 1'b1 || err === 1'b1));
    q = rdat;
    k = ack;
    e = err;
    c = claimed;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // released lines show no stale value
    adr <= ~a;
    wdat <= ~d;
  endtask : access
endmodule : sram_core_model
`default_nettype wire

/* testbench/sram_map_bench.sv */
// self-checking bench for the standby ram mapping block
`default_nettype none
module sram_map_bench
  import sram_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic w; logic [23:0] a; logic [3:0] s; logic [31:0] d;
    logic sv; logic pg; logic ok; logic [31:0] x;
  } sram_row_s;
  localparam logic [23:0] CFG1 = {1'b1, CTRL_BLOCK_BASE};
  localparam logic [23:0] BAS1 = CFG1 + 24'h000004;
  localparam logic [23:0] CFG0 = {1'b0, CTRL_BLOCK_BASE};
  localparam logic [31:0] Z = 32'h00000000;
  // write/read rows: dir, addr, lanes, data, sup, prog, claimed, read
  localparam sram_row_s ROWS [19] = '{
    {1'b1, BAS1, 4'h6, 32'h00012000, 3'b101, Z},
    {1'b0, BAS1, 4'hF, Z, 3'b101, 32'h00012000},
    {1'b0, 24'h012000, 4'hF, Z, 3'b100, Z},
    {1'b1, CFG1, 4'hC, Z, 3'b101, Z},
    {1'b1, 24'h012000, 4'hF, 32'h11223344, 3'b001, Z},
    {1'b1, 24'h012000, 4'h1, 32'h000000AA, 3'b011, Z},
    {1'b1, 24'h012000, 4'hC, 32'h55660000, 3'b001, Z},
    {1'b0, 24'h012000, 4'hF, Z, 3'b001, 32'h556633AA},
    {1'b1, 24'h012FFC, 4'hF, 32'hCAFEF00D, 3'b111, Z},
    {1'b0, 24'h012FFC, 4'hF, Z, 3'b011, 32'hCAFEF00D},
    {1'b0, 24'h013000, 4'hF, Z, 3'b100, Z},
    {1'b0, 24'h011FFC, 4'hF, Z, 3'b100, Z},
    {1'b1, CFG1, 4'h3, 32'h0000FFFF, 3'b101, Z},
    {1'b0, CFG1, 4'hF, Z, 3'b101, Z},
    {1'b1, BAS1, 4'h6, 32'h00020000, 3'b101, Z},
    {1'b0, BAS1, 4'hF, Z, 3'b101, 32'h00012000},
    {1'b0, CFG1, 4'hF, Z, 3'b000, Z},
    {1'b0, CFG1, 4'hF, Z, 3'b110, Z},
    {1'b0, CFG1 - 24'h800000, 4'hF, Z, 3'b100, Z}};
  logic        clk, reset_n, mm, cyc, stb, we, sup, prg;
  logic        ack, err, claimed, k, e, c, x;
  logic [23:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  int          n, n_fail, n_compared;

  sram_map i_sram_map (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .supervisor(sup), .program_space(prg), .module_map_select(mm),
    .access_claimed(claimed));
  sram_core_model i_sram_core_model (.clk(clk), .cyc(cyc), .stb(stb),
    .we(we), .adr(adr), .sel(sel), .wdat(wdat), .supervisor(sup),
    .program_space(prg), .rdat(rdat), .ack(ack), .err(err),
    .claimed(claimed));

  // compare, count, report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [23:0] a,
                     input logic [3:0] s, input logic [31:0] d,
                     input logic sv, input logic pg);
    i_sram_core_model.access(w, a, s, d, sv, pg, q, k, e, c, n);
  endtask : acc
  task automatic rd(input logic [23:0] a, input logic [31:0] exp);
    acc(1'b0, a, 4'hF, Z, 1'b1, 1'b0);
    chk(q, exp);
  endtask : rd
  task automatic do_reset;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
  endtask : do_reset
  task automatic end_of_test;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // ------------------------------------------------------------------
  // clock, watchdog, sequence
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // generous bound: the run needs under two hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
  initial begin
    reset_n = 1'b0;
    mm = 1'b1;
    n_fail = 0;
    n_compared = 0;
    do_reset();
    rd(CFG1, 32'h83000000);
    foreach (ROWS[i]) begin
      acc(ROWS[i].w, ROWS[i].a, ROWS[i].s, ROWS[i].d, ROWS[i].sv,
          ROWS[i].pg);
      chk({k, e, c}, {ROWS[i].ok, !ROWS[i].ok, ROWS[i].ok});
      chk(32'(n), ACCESS_CYCLES);
      if (!ROWS[i].w && ROWS[i].ok)
        chk(q, ROWS[i].x);
    end
    // every space setting against every mode and space type
    for (int sp = 0; sp < 4; sp++) begin
      acc(1'b1, CFG1, 4'h4, {6'h00, 2'(sp), 24'h000000}, 1'b1, 1'b0);
      for (int m = 0; m < 4; m++) begin
        acc(1'b0, 24'h012FFC, 4'hF, Z, m[0], m[1]);
        x = (!sp[0] || m[0]) && (!sp[1] || m[1]);
        chk({k, c}, {x, x});
      end
    end
    // lock: base movable while stopped, frozen once locked
    acc(1'b1, CFG1, 4'h8, 32'h80000000, 1'b1, 1'b0);
    acc(1'b1, BAS1, 4'h6, 32'h00020000, 1'b1, 1'b0);
    rd(BAS1, 32'h00020000);
    acc(1'b1, CFG1, 4'h8, 32'hC0000000, 1'b1, 1'b0);
    acc(1'b1, CFG1, 4'h8, 32'h80000000, 1'b1, 1'b0);
    rd(CFG1, 32'hC3000000);
    acc(1'b1, BAS1, 4'h6, 32'h00030000, 1'b1, 1'b0);
    rd(BAS1, 32'h00020000);
    // only reset unlocks; module map moves the register block
    do_reset();
    rd(CFG1, 32'h83000000);
    mm <= 1'b0;
    rd(CFG0, 32'h83000000);
    rd(BAS1 - 24'h800000, Z);
    mm <= 1'b1;
    // array placed over the register block hides the registers
    acc(1'b1, BAS1, 4'h6, 32'h00FFF000, 1'b1, 1'b0);
    acc(1'b1, CFG1, 4'hC, Z, 1'b1, 1'b0);
    acc(1'b1, CFG1, 4'hF, 32'h12345678, 1'b1, 1'b0);
    rd(CFG1, 32'h12345678);
    end_of_test();
  end
endmodule : sram_map_bench
`default_nettype wire
